// file: inc/jpr_pkg.sv
// Package with register map and field positions for the joystick port registers
package jpr_pkg;
	// Register word indices; each register takes one aligned APB word
	localparam logic [7:0] OFS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_PIN_LEVELS = 8'h01;
	localparam logic [7:0] OFS_EVENT_FLAGS = 8'h02;
	localparam logic [7:0] OFS_IRQ_ENABLES = 8'h03;
	localparam logic [7:0] OFS_A_HORIZ_LO = 8'h04;
	localparam logic [7:0] OFS_A_HORIZ_HI = 8'h05;
	localparam logic [7:0] OFS_A_VERT_LO = 8'h06;
	localparam logic [7:0] OFS_A_VERT_HI = 8'h07;
	localparam logic [7:0] OFS_B_HORIZ_LO = 8'h08;
	localparam logic [7:0] OFS_B_HORIZ_HI = 8'h09;
	localparam logic [7:0] OFS_B_VERT_LO = 8'h0a;
	localparam logic [7:0] OFS_B_VERT_HI = 8'h0b;
	localparam logic [7:0] OFS_EDGE_SELECT = 8'h0c;
	// Control bit positions
	localparam int CTL_ENHANCED = 0;
	// Irq enable bit positions
	localparam int IEN_POS_A = 0;
	localparam int IEN_POS_B = 1;
	localparam int IEN_POS_EITHER = 2;
	localparam int IEN_BTN_LSB = 4;
	// Event flags: bits 3..0 counter ready, 7..4 button events
	localparam int EVT_BTN_LSB = 4;
	// Writable masks; bit 3 of control and enables is reserved
	localparam logic [7:0] CTL_WMASK = 8'hf7;
	localparam logic [7:0] IEN_WMASK = 8'hf7;
	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	// Edge select codes
	localparam logic [1:0] EDGE_NONE = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
	// Number of buttons, axes and synchroniser stages
	localparam int NUM_BTN = 4;
	localparam int NUM_AXIS = 4;
	localparam int SYNC_STAGES = 3;
endpackage

// file: rtl/jpr_edge_detect.sv
// Button edge detector driven by a two-bit edge select code
`timescale 1ns/1ps
module jpr_edge_detect (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [3:0] level,
	input wire logic [7:0] edge_select,
	output logic [3:0] hit
);
	typedef struct packed {
		logic [3:0] prev;
	} jpr_edge_s;
	jpr_edge_s st, next_st;

	// Decode one field against a rise and fall pair
	function automatic logic edge_match(input logic [1:0] code, input logic rise, input logic fall);
		case (code)
			jpr_pkg::EDGE_RISE: edge_match = rise;
			jpr_pkg::EDGE_FALL: edge_match = fall;
			jpr_pkg::EDGE_BOTH: edge_match = rise | fall;
			default: edge_match = 1'b0;
		endcase
	endfunction

	always_comb begin
		next_st.prev = level;
		for (int i = 0; i < jpr_pkg::NUM_BTN; i++) begin
			hit[i] = edge_match(edge_select[2*i +: 2], level[i] & ~st.prev[i], ~level[i] & st.prev[i]);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
endmodule

// file: rtl/jpr_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module jpr_pin_sync (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] pin_in,
	output logic [7:0] pin_level
);
	typedef struct packed {
		logic [7:0] s1;
		logic [7:0] s2;
		logic [7:0] s3;
		logic [7:0] lvl;
	} jpr_sync_s;
	jpr_sync_s st, next_st;

	// Level changes only once stages two and three agree; stage one feeds stage two alone
	always_comb begin
		next_st = st;
		next_st.s1 = pin_in;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		for (int i = 0; i < 8; i++) begin
			if (st.s2[i] == st.s3[i]) begin
				next_st.lvl[i] = st.s3[i];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign pin_level = st.lvl;
endmodule

// file: rtl/jpr_regs.sv
// Joystick port register block with APB slave, event flags and interrupt
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
module jpr_regs (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [3:0] button_pins,
	input wire logic [3:0] axis_pins,
	input wire logic [63:0] axis_count,
	input wire logic [3:0] axis_done,
	output logic [7:0] port_control,
	output logic irq
);
	typedef struct packed {
		logic [7:0] control;
		logic [7:0] flags;
		logic [7:0] enables;
		logic [7:0] edge_sel;
		logic [63:0] latched;
		logic [31:0] rdata;
		logic pos_a_pend;
		logic pos_b_pend;
	} jpr_regs_s;
	jpr_regs_s st, next_st;

	logic [7:0] pin_levels;
	logic [3:0] btn_hit;
	logic enhanced;
	logic wr_en;
	logic rd_en;
	logic addr_ok;
	logic [7:0] rd_byte;
	logic [3:0] ready_now;

	// Pins reach this clock through the filter; axis pins join the buttons
	jpr_pin_sync u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.pin_in({button_pins, axis_pins}),
		.pin_level(pin_levels)
	);

	// Edge select is forced to none outside enhanced mode
	jpr_edge_detect u_edge (
		.pclk(pclk),
		.presetn(presetn),
		.level(pin_levels[7:4]),
		.edge_select(enhanced ? st.edge_sel : jpr_pkg::RST_BYTE),
		.hit(btn_hit)
	);

	// Word index of a byte address; the two low address bits must be zero for a hit
	function automatic logic [7:0] word_index(input logic [7:0] addr);
		word_index = {2'h0, addr[7:2]};
	endfunction

	// Select byte of a latched 64-bit counter bundle
	function automatic logic [7:0] count_byte(input logic [63:0] cnt, input logic [2:0] idx);
		count_byte = cnt[8*idx +: 8];
	endfunction

	// APB decode: zero-wait, answered in the access cycle
	always_comb begin
		enhanced = st.control[jpr_pkg::CTL_ENHANCED];
		wr_en = psel & penable & pwrite;
		rd_en = psel & ~penable & ~pwrite;
		addr_ok = (paddr[1:0] == 2'h0) && (word_index(paddr) <= jpr_pkg::OFS_EDGE_SELECT);
		ready_now = st.flags[3:0];
	end

	// Read mux; position bytes read zero outside enhanced mode
	always_comb begin
		rd_byte = jpr_pkg::RST_BYTE;
		case (word_index(paddr))
			jpr_pkg::OFS_CONTROL: rd_byte = st.control;
			jpr_pkg::OFS_PIN_LEVELS: rd_byte = pin_levels;
			jpr_pkg::OFS_EVENT_FLAGS: rd_byte = st.flags;
			jpr_pkg::OFS_IRQ_ENABLES: rd_byte = st.enables;
			jpr_pkg::OFS_A_HORIZ_LO, jpr_pkg::OFS_A_HORIZ_HI, jpr_pkg::OFS_A_VERT_LO, jpr_pkg::OFS_A_VERT_HI,
			jpr_pkg::OFS_B_HORIZ_LO, jpr_pkg::OFS_B_HORIZ_HI, jpr_pkg::OFS_B_VERT_LO,
			jpr_pkg::OFS_B_VERT_HI: begin
				if (enhanced) begin
					rd_byte = count_byte(st.latched, 3'(word_index(paddr) - jpr_pkg::OFS_A_HORIZ_LO));
				end
			end
			jpr_pkg::OFS_EDGE_SELECT: rd_byte = st.edge_sel;
			default: rd_byte = jpr_pkg::RST_BYTE;
		endcase
	end

	// Register updates; hardware set beats software clear for button flags; a counter ready flag is only set while it is clear
	always_comb begin
		next_st = st;
		if (rd_en) begin
			next_st.rdata = {24'h000000, addr_ok ? rd_byte : jpr_pkg::RST_BYTE};
		end
		if (wr_en && addr_ok) begin
			case (word_index(paddr))
				jpr_pkg::OFS_CONTROL: next_st.control = pwdata[7:0] & jpr_pkg::CTL_WMASK;
				jpr_pkg::OFS_EVENT_FLAGS: next_st.flags = st.flags & ~pwdata[7:0];
				jpr_pkg::OFS_IRQ_ENABLES: next_st.enables = pwdata[7:0] & jpr_pkg::IEN_WMASK;
				jpr_pkg::OFS_EDGE_SELECT: next_st.edge_sel = pwdata[7:0];
				default: next_st = next_st;
			endcase
		end
		// Counter captured only when its ready flag is clear, so two byte reads stay coherent
		for (int i = 0; i < jpr_pkg::NUM_AXIS; i++) begin
			if (axis_done[i] && !ready_now[i] && enhanced) begin
				next_st.latched[16*i +: 16] = axis_count[16*i +: 16];
				next_st.flags[i] = 1'b1;
			end
		end
		// Button events set their flags
		for (int i = 0; i < jpr_pkg::NUM_BTN; i++) begin
			if (btn_hit[i]) begin
				next_st.flags[jpr_pkg::EVT_BTN_LSB + i] = 1'b1;
			end
		end
		// Position trigger per device, both or either axis; new selection applies with the write itself
		next_st.pos_a_pend = next_st.enables[jpr_pkg::IEN_POS_EITHER] ? (next_st.flags[0] | next_st.flags[1])
			: (next_st.flags[0] & next_st.flags[1]);
		next_st.pos_b_pend = next_st.enables[jpr_pkg::IEN_POS_EITHER] ? (next_st.flags[2] | next_st.flags[3])
			: (next_st.flags[2] & next_st.flags[3]);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// Interrupt level from enabled sources only
	always_comb begin
		irq = (|(st.flags[7:4] & st.enables[7:4]))
			| (st.pos_a_pend & st.enables[jpr_pkg::IEN_POS_A])
			| (st.pos_b_pend & st.enables[jpr_pkg::IEN_POS_B]);
	end

	assign prdata = st.rdata;
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign port_control = st.control;
endmodule

// file: tb/jpr_regs_chk.sv
// Port assertions for the joystick register block
`timescale 1ns/1ps
module jpr_regs_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [7:0] port_control,
	input wire logic irq
);
	logic rd;
	logic wr;
	logic [7:0] sel_copy;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	assign rd = psel && !penable && !pwrite;
	assign wr = psel && penable && pwrite;
	// Shadow of the edge select byte for read-back
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_copy <= 8'h00;
		end else if (wr && paddr == 8'h30) begin
			sel_copy <= pwdata[7:0];
		end
	end
	property p_sel; rd && paddr == 8'h30 |=> prdata[7:0] == sel_copy; endproperty
	a_sel: assert property (p_sel) else $error("edge select readback");
	property p_off; rd && !port_control[0] && paddr inside {8'h20, 8'h24, 8'h28, 8'h2c} |=> prdata == 0; endproperty
	a_off: assert property (p_off) else $error("position byte outside enhanced");
	property p_ctl; wr && paddr == 8'h00 |=> port_control == (jpr_pkg::CTL_WMASK & $past(pwdata[7:0])); endproperty
	a_ctl: assert property (p_ctl) else $error("control write");
	property p_keep; wr && paddr != 8'h00 |=> $stable(port_control); endproperty
	a_keep: assert property (p_keep) else $error("control disturbed");
	property p_irq; wr && paddr == 8'h0c && pwdata[7:0] == 8'h00 |=> !irq; endproperty
	a_irq: assert property (p_irq) else $error("irq with enables clear");
	property p_oob; rd && paddr > 8'h30 |=> prdata == 0; endproperty
	a_oob: assert property (p_oob) else $error("unmapped read");
	property p_up; rd |=> prdata[31:8] == 24'h0; endproperty
	a_up: assert property (p_up) else $error("upper read bits");
	property p_rdy; psel && penable |-> pready && !pslverr; endproperty
	a_rdy: assert property (p_rdy) else $error("bus answer");
	c_irq: cover property ($rose(irq));
	c_sel: cover property (rd && paddr == 8'h30);
	c_pos: cover property (rd && port_control[0] && paddr == 8'h24);
endmodule
bind jpr_regs jpr_regs_chk u_chk (.*);

// file: tb/jpr_stick_model.sv
// Far-side joystick model: button levels and finished axis counts
`timescale 1ns/1ps
module jpr_stick_model (
	input wire logic pclk,
	output logic [3:0] button_pins,
	output logic [3:0] axis_pins,
	output logic [63:0] axis_count,
	output logic [3:0] axis_done
);
	// Idle sticks: buttons up, nothing measured
	initial begin
		button_pins = 4'h0;
		axis_pins = 4'h0;
		axis_count = 64'h0;
		axis_done = 4'h0;
	end
	// One-cycle completion pulse carrying the count
	task automatic finish(input int i, input logic [15:0] v);
		@(posedge pclk);
		axis_count[16*i+:16] <= v;
		axis_done[i] <= 1'b1;
		@(posedge pclk);
		axis_done[i] <= 1'b0;
	endtask
	// Button level change
	task automatic press(input int i, input logic v);
		@(posedge pclk);
		button_pins[i] <= v;
	endtask
endmodule

// file: tb/tb_joystick_position_button_regs.sv
// Self-checking bench for the joystick register block
`timescale 1ns/1ps
module tb_joystick_position_button_regs;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
	logic [7:0] paddr;
	logic [7:0] port_control;
	logic [31:0] pwdata, prdata, q;
	logic [3:0] button_pins, axis_pins, axis_done;
	logic [63:0] axis_count;
	int bad_count = 0;
	int n_checks = 0;
	jpr_regs u_dut (.*);
	jpr_stick_model u_stk (.*);
	task automatic end_sim;
		$display("checks %0d errors %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("Error %s exp %h got %h", s, e, g);
		end
	endtask
	// One APB transfer; request held until pready is seen
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			bad_count++;
			end_sim;
		end
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rchk(input string s, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(s, e, q);
	endtask
	// irq is combinational: look once the edge has settled
	task automatic ichk(input logic e);
		@(negedge pclk);
		chk("irq", {31'h0, e}, {31'h0, irq});
	endtask
	task automatic s_reset;
		logic [7:0] ra [8] = '{8'h00, 8'h08, 8'h0c, 8'h20, 8'h24, 8'h28, 8'h2c, 8'h30};
		foreach (ra[i]) rchk("reset", ra[i], 32'h0);
		ichk(1'b0);
	endtask
	// Device A bytes, either-axis trigger, ready flags polled first
	task automatic s_pos_a;
		int n;
		apb(1'b1, 8'h0c, 32'h5);
		u_stk.finish(0, 16'h1234);
		n = 0;
		do begin
			apb(1'b0, 8'h08, 32'h0);
			n++;
		end while (q[0] !== 1'b1 && n < 50);
		chk("a ready", 32'h1, q & 32'h3);
		ichk(1'b1);
		u_stk.finish(1, 16'h8765);
		rchk("ax lo", 8'h10, 32'h34);
		rchk("ax hi", 8'h14, 32'h12);
		rchk("a ready", 8'h08, 32'h3);
		rchk("ay lo", 8'h18, 32'h65);
		rchk("ay hi", 8'h1c, 32'h87);
		apb(1'b1, 8'h08, 32'h3);
		ichk(1'b0);
	endtask
	task automatic s_pos;
		int n;
		apb(1'b1, 8'h00, 32'h1);
		apb(1'b1, 8'h0c, 32'h2);
		u_stk.finish(2, 16'h5aa5);
		u_stk.finish(3, 16'hc33c);
		n = 0;
		do begin
			apb(1'b0, 8'h08, 32'h0);
			n++;
		end while (q[3:2] !== 2'h3 && n < 50);
		chk("ready", 32'hc, q & 32'hc);
		ichk(1'b1);
		u_stk.finish(2, 16'h1111);
		rchk("bx lo", 8'h20, 32'ha5);
		rchk("bx hi", 8'h24, 32'h5a);
		rchk("by lo", 8'h28, 32'h3c);
		apb(1'b1, 8'h2c, 32'hff);
		rchk("by hi", 8'h2c, 32'hc3);
		apb(1'b1, 8'h08, 32'h8);
		ichk(1'b0);
		apb(1'b1, 8'h0c, 32'h6);
		ichk(1'b1);
		apb(1'b1, 8'h0c, 32'h4);
		ichk(1'b0);
		apb(1'b1, 8'h08, 32'hf);
	endtask
	// Button i gets code i, so every code and field is used
	task automatic s_btn;
		apb(1'b1, 8'h0c, 32'hf0);
		apb(1'b1, 8'h30, 32'he4);
		rchk("sel", 8'h30, 32'he4);
		for (int i = 0; i < 4; i++) begin
			for (int v = 1; v >= 0; v--) begin
				u_stk.press(i, v[0]);
				repeat (10) @(posedge pclk);
				rchk("btn flag", 8'h08, (v ? i & 1 : i >> 1) << (4 + i));
				ichk(v ? i & 1 : i >> 1);
				apb(1'b1, 8'h08, 32'hf0);
			end
		end
	endtask
	task automatic s_off;
		apb(1'b1, 8'h0c, 32'h0);
		ichk(1'b0);
		apb(1'b1, 8'h00, 32'h0);
		rchk("off", 8'h24, 32'h0);
		rchk("oob", 8'h34, 32'h0);
	endtask
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		s_reset;
		s_pos;
		s_pos_a;
		s_btn;
		s_off;
		end_sim;
	end
endmodule
